// >>> hdl/blr_regs.vh
`ifndef BLR_REGS_VH
`define BLR_REGS_VH
// Notes on behaviour
// RULE1: bit ops act on one of seven general registers; destination field zero picks flags.
// RULE2: bit number comes from instruction bits 3 to 6.
// RULE3: sixteen bit sub-operations decoded, using one-bit accumulator for temporaries.
// RULE4: test forms skip when bit is zero, or when bit is one.
// RULE5: compare forms skip when inverted bit, or the bit, equals the accumulator.
// RULE6: write forms force bit to zero, one, invert it, or copy accumulator.
// RULE7: store forms write accumulator then clear it, or inverse then set it.
// RULE8: load forms copy bit or inverse into accumulator, source unchanged.
// RULE9: logic forms AND or OR accumulator with bit or inverted bit.
// RULE10: supervisor call raises internal interrupt to level 14, not privileged.
// RULE11: supervisor call parameter sign-extended into level 14 T register.
// RULE12: privileged instructions run only in rings 2 and 3 or stop mode.
// RULE13: block is eight words P X T A D L flags B; flags high byte zero.
// RULE14: block store writes named level's block from address in current X.
// RULE15: block store of current level saves address of the following instruction.
// RULE16: block load fills named level from memory; current level keeps its P.
// RULE17: register file holds sixteen full register sets, one per level.
// RULE18: cross-level access takes register code bits 0-2, level bits 3-6.
// RULE19: cross-level read puts register into current A; code zero reads flags low.
// RULE20: cross-level write puts current A into register; code zero writes flags low.
// RULE21: cross-level write to current level program counter does nothing.
// RULE22: block and cross-level instructions refused outside permitted modes; bit ops free.
// RULE23: refused privileged instruction raises protection interrupt, changes nothing.

// opcodes: top bits of each instruction group, low three bits for the block transfers
`define BLR_OP_BIT 5'h1F
`define BLR_OP_SVC 8'hD6
`define BLR_OP_SRB 9'h1AA
`define BLR_OP_SRB_LO 3'h2
`define BLR_OP_LRB 9'h1AB
`define BLR_OP_LRB_LO 3'h0
`define BLR_OP_IRR 9'h1AF
`define BLR_OP_IRW 9'h1AE
// register codes inside a set
`define BLR_R_FLAG 3'h0
`define BLR_R_D 3'h1
`define BLR_R_P 3'h2
`define BLR_R_B 3'h3
`define BLR_R_L 3'h4
`define BLR_R_A 3'h5
`define BLR_R_T 3'h6
`define BLR_R_X 3'h7
`define BLR_SVC_LEVEL 4'hE
`define BLR_BLOCK_WORDS 4'h8
// flag register bit of the one-bit accumulator
`define BLR_K_BIT 4'h2
`define BLR_FLAG_RESET 16'h0000
`endif

// >>> hdl/blr_bitalu.v
`timescale 1ns/1ps
`include "blr_regs.vh"
// ************************************************
// single bit operation unit
// ************************************************
module blr_bitalu (
  input wire [3:0] sub_op, // sub-instruction field
  input wire bit_in, // selected bit
  input wire k_in, // one-bit accumulator
  output reg bit_out, // new bit value
  output reg bit_we, // bit is written
  output reg k_out, // new accumulator
  output reg skip // skip next instruction
);
  // decode the sixteen sub-operations
  always @* begin
    bit_out = bit_in;
    bit_we = 1'b0;
    k_out = k_in;
    skip = 1'b0;
    case (sub_op) // RULE3
      4'h0: skip = ~bit_in; // RULE4
      4'h1: skip = bit_in; // RULE4
      4'h2: skip = (~bit_in) == k_in; // RULE5
      4'h3: skip = bit_in == k_in; // RULE5
      4'h4: begin
        bit_out = 1'b0; // RULE6
        bit_we = 1'b1;
      end
      4'h5: begin
        bit_out = 1'b1; // RULE6
        bit_we = 1'b1;
      end
      4'h6: begin
        bit_out = ~bit_in; // RULE6
        bit_we = 1'b1;
      end
      4'h7: begin
        bit_out = k_in; // RULE6
        bit_we = 1'b1;
      end
      4'h8: begin
        bit_out = k_in; // RULE7
        bit_we = 1'b1;
        k_out = 1'b0;
      end
      4'h9: begin
        bit_out = ~k_in; // RULE7
        bit_we = 1'b1;
        k_out = 1'b1;
      end
      4'hA: k_out = bit_in; // RULE8
      4'hB: k_out = ~bit_in; // RULE8
      4'hC: k_out = (~bit_in) & k_in; // RULE9
      4'hD: k_out = (~bit_in) | k_in; // RULE9
      4'hE: k_out = bit_in & k_in; // RULE9
      4'hF: k_out = bit_in | k_in; // RULE9
      default: skip = 1'b0;
    endcase
  end
endmodule

// >>> hdl/blr_exec.v
`timescale 1ns/1ps
`include "blr_regs.vh"
// ************************************************
// bit, supervisor call and level register execution
// ************************************************
module blr_exec #(
  parameter LEVELS = 16 // register sets, one per level
) (
  input wire core_clk, // cpu clock
  input wire rst_b, // synchronous reset, active low
  input wire instr_valid, // instruction strobe
  input wire [15:0] instr_word, // instruction
  input wire [3:0] cur_level, // current program level
  input wire [1:0] cur_ring, // current ring
  input wire stop_mode, // cpu in stop mode
  input wire [15:0] cur_pc, // address of this instruction
  output reg busy, // executing
  output reg done, // finished pulse
  output reg skip, // skip next instruction
  output reg svc_irq, // internal interrupt to level 14
  output reg prot_irq, // protection interrupt
  output reg illegal, // not an instruction of this block
  output reg mem_req, // memory request
  output reg mem_we, // memory write
  output reg [15:0] mem_addr, // memory address
  output reg [15:0] mem_wdata, // memory write data
  input wire mem_ack, // memory answer
  input wire [15:0] mem_rdata, // memory read data
  input wire [3:0] dbg_level, // debug read level
  input wire [2:0] dbg_code, // debug read register
  output reg [15:0] dbg_data // debug read data
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MEM = 2'h1;
  localparam ST_WAIT = 2'h2;

  // register file: level*8+code; code 0 holds flags
  reg [15:0] rf_reg [0:LEVELS*8-1]; // RULE17
  reg [1:0] state_reg;
  reg [15:0] ir_reg;
  reg [2:0] word_reg;
  reg [15:0] addr_reg;
  reg [15:0] pc1_reg;
  integer i;

  wire [3:0] f_level = instr_word[6:3]; // RULE18
  wire [2:0] f_code = instr_word[2:0]; // RULE18
  wire [3:0] f_bitn = instr_word[6:3]; // RULE2
  wire [3:0] f_sub = instr_word[10:7];
  wire priv_ok = (cur_ring[1] == 1'b1) | stop_mode; // RULE12
  wire is_bit = instr_word[15:11] == `BLR_OP_BIT;
  wire is_svc = instr_word[15:8] == `BLR_OP_SVC;
  wire is_srb = (instr_word[15:7] == `BLR_OP_SRB) & (instr_word[2:0] == `BLR_OP_SRB_LO);
  wire is_lrb = (instr_word[15:7] == `BLR_OP_LRB) & (instr_word[2:0] == `BLR_OP_LRB_LO);
  wire is_irr = instr_word[15:7] == `BLR_OP_IRR;
  wire is_irw = instr_word[15:7] == `BLR_OP_IRW;
  wire is_priv = is_srb | is_lrb | is_irr | is_irw; // RULE22

  // index of a register in the file
  function [6:0] rf_idx;
    input [3:0] lvl;
    input [2:0] code;
    begin
      rf_idx = {lvl, code};
    end
  endfunction

  // register code of block word n
  function [2:0] blk_code;
    input [2:0] n;
    begin
      case (n) // RULE13
        3'h0: blk_code = `BLR_R_P;
        3'h1: blk_code = `BLR_R_X;
        3'h2: blk_code = `BLR_R_T;
        3'h3: blk_code = `BLR_R_A;
        3'h4: blk_code = `BLR_R_D;
        3'h5: blk_code = `BLR_R_L;
        3'h6: blk_code = `BLR_R_FLAG;
        default: blk_code = `BLR_R_B;
      endcase
    end
  endfunction

  // bit operation operands
  wire [6:0] bop_idx = (f_code == 3'h0) ? rf_idx(cur_level, `BLR_R_FLAG) : rf_idx(cur_level, f_code); // RULE1
  wire [15:0] bop_word = rf_reg[bop_idx];
  wire [6:0] k_idx = rf_idx(cur_level, `BLR_R_FLAG);
  wire k_val = rf_reg[k_idx][`BLR_K_BIT];
  wire bop_bit = bop_word[f_bitn];
  wire bop_new;
  wire bop_we;
  wire bop_k;
  wire bop_skip;

  blr_bitalu u_bitalu (
    .sub_op(f_sub),
    .bit_in(bop_bit),
    .k_in(k_val),
    .bit_out(bop_new),
    .bit_we(bop_we),
    .k_out(bop_k),
    .skip(bop_skip)
  );

  // block transfer operands
  wire [3:0] blk_level = ir_reg[6:3];
  wire [2:0] blk_c = blk_code(word_reg);
  wire [6:0] blk_idx = rf_idx(blk_level, blk_c);
  wire blk_cur = blk_level == cur_level;
  wire [15:0] blk_raw = rf_reg[blk_idx];
  wire [15:0] blk_word = (blk_c == `BLR_R_FLAG) ? {8'h00, blk_raw[7:0]} :
                         ((blk_c == `BLR_R_P) & blk_cur) ? pc1_reg : blk_raw; // RULE13 RULE15
  wire [15:0] irr_raw = rf_reg[rf_idx(f_level, f_code)];
  wire [15:0] cur_a = rf_reg[rf_idx(cur_level, `BLR_R_A)];
  wire [15:0] svc_ext = {{8{instr_word[7]}}, instr_word[7:0]}; // RULE11

  // ************************************************
  // sequencer and register file update
  // ************************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      ir_reg <= 16'h0000;
      word_reg <= 3'h0;
      addr_reg <= 16'h0000;
      pc1_reg <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      skip <= 1'b0;
      svc_irq <= 1'b0;
      prot_irq <= 1'b0;
      illegal <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      for (i = 0; i < LEVELS*8; i = i + 1) begin
        rf_reg[i] <= `BLR_FLAG_RESET;
      end
    end else begin
      done <= 1'b0;
      skip <= 1'b0;
      svc_irq <= 1'b0;
      prot_irq <= 1'b0;
      illegal <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (instr_valid) begin
            ir_reg <= instr_word;
            pc1_reg <= cur_pc + 16'h0001;
            word_reg <= 3'h0;
            addr_reg <= rf_reg[rf_idx(cur_level, `BLR_R_X)]; // RULE14
            if (is_priv && !priv_ok) begin
              prot_irq <= 1'b1; // RULE23
              done <= 1'b1;
            end else if (is_bit) begin
              if (bop_we) begin
                rf_reg[bop_idx][f_bitn] <= bop_new;
              end
              // accumulator forms always write k, after any bit write to the same flag
              if (f_sub[3]) begin
                rf_reg[k_idx][`BLR_K_BIT] <= bop_k; // RULE7
              end
              skip <= bop_skip;
              done <= 1'b1;
            end else if (is_svc) begin
              rf_reg[rf_idx(`BLR_SVC_LEVEL, `BLR_R_T)] <= svc_ext; // RULE11
              svc_irq <= 1'b1; // RULE10
              done <= 1'b1;
            end else if (is_irr) begin
              if (f_code == `BLR_R_FLAG) begin
                rf_reg[rf_idx(cur_level, `BLR_R_A)] <= {8'h00, irr_raw[7:0]}; // RULE19
              end else begin
                rf_reg[rf_idx(cur_level, `BLR_R_A)] <= irr_raw; // RULE19
              end
              done <= 1'b1;
            end else if (is_irw) begin
              if (f_code == `BLR_R_FLAG) begin
                rf_reg[rf_idx(f_level, f_code)][7:0] <= cur_a[7:0]; // RULE20
              end else if (!((f_code == `BLR_R_P) && (f_level == cur_level))) begin // RULE21
                rf_reg[rf_idx(f_level, f_code)] <= cur_a; // RULE20
              end
              done <= 1'b1;
            end else if (is_srb || is_lrb) begin
              busy <= 1'b1;
              state_reg <= ST_MEM;
            end else begin
              illegal <= 1'b1;
              done <= 1'b1;
            end
          end
        end
        ST_MEM: begin
          // issue one block word
          mem_req <= 1'b1;
          mem_we <= ir_reg[2:0] == `BLR_OP_SRB_LO;
          mem_addr <= addr_reg;
          mem_wdata <= blk_word; // RULE14
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (ir_reg[2:0] == `BLR_OP_LRB_LO) begin
              if (blk_c == `BLR_R_FLAG) begin
                rf_reg[blk_idx][7:0] <= mem_rdata[7:0];
              end else if (!((blk_c == `BLR_R_P) && blk_cur)) begin // RULE16
                rf_reg[blk_idx] <= mem_rdata; // RULE16
              end
            end
            addr_reg <= addr_reg + 16'h0001;
            word_reg <= word_reg + 3'h1;
            if (word_reg == 3'h7) begin
              busy <= 1'b0;
              done <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_MEM;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // debug view of the register file
  always @(posedge core_clk) begin
    if (!rst_b) begin
      dbg_data <= 16'h0000;
    end else begin
      dbg_data <= rf_reg[rf_idx(dbg_level, dbg_code)];
    end
  end
endmodule

// >>> sim/blr_exec_asserts.sv
`timescale 1ns/1ps
`include "blr_regs.vh"
// ************************************************
// execution unit checker
// ************************************************
module blr_exec_asserts #(parameter LEVELS = 16) (
  input wire core_clk, // clock
  input wire rst_b, // reset
  input wire instr_valid, // strobe
  input wire [15:0] instr_word, // word
  input wire [1:0] cur_ring, // ring
  input wire stop_mode, // stop
  input wire busy, // busy
  input wire done, // done
  input wire svc_irq, // svc
  input wire prot_irq, // refused
  input wire mem_req, // request
  input wire mem_we, // write
  input wire [15:0] mem_addr, // address
  input wire [15:0] mem_wdata, // data
  input wire mem_ack // answer
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  reg [3:0] ack_cnt_reg;
  reg [15:0] last_addr_reg;
  // decode of the offered word
  wire take = instr_valid && !busy;
  wire ok_mode = cur_ring[1] || stop_mode;
  wire blk = {instr_word[15:7], instr_word[2:0]} == {`BLR_OP_SRB, `BLR_OP_SRB_LO} ||
    {instr_word[15:7], instr_word[2:0]} == {`BLR_OP_LRB, `BLR_OP_LRB_LO};
  wire priv = blk || instr_word[15:7] == `BLR_OP_IRR || instr_word[15:7] == `BLR_OP_IRW;
  // words answered in the running block transfer
  always @(posedge core_clk) begin
    if (!rst_b || !busy) begin
      ack_cnt_reg <= 4'h0;
    end else if (mem_req && mem_ack) begin
      ack_cnt_reg <= ack_cnt_reg + 4'h1;
      last_addr_reg <= mem_addr;
    end
  end
  a_refuse_priv: assert property (take && priv && !ok_mode |=> done && prot_irq && !busy)
    else $error("privileged word not refused");
  a_prot_cause: assert property (prot_irq |-> $past(take && priv && !ok_mode))
    else $error("refusal without cause");
  a_block_start: assert property (take && blk && ok_mode |=> busy ##1 mem_req)
    else $error("block transfer did not start");
  a_bit_free: assert property (take && instr_word[15:11] == `BLR_OP_BIT |=> done && !prot_irq)
    else $error("bit operation refused");
  a_svc_raise: assert property (take && instr_word[15:8] == `BLR_OP_SVC |=> done && svc_irq && !prot_irq)
    else $error("supervisor call gave no interrupt");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("request dropped early");
  a_addr_step: assert property ($rose(mem_req) && ack_cnt_reg != 4'h0 |-> mem_addr == last_addr_reg + 16'h0001)
    else $error("block address not successive");
  a_block_len: assert property (done && $past(busy) |-> ack_cnt_reg == 4'h8)
    else $error("block length not eight words");
  a_flag_word: assert property (mem_req && mem_we && ack_cnt_reg == 4'h6 |-> mem_wdata[15:8] == 8'h00)
    else $error("flag word high byte set");
  a_req_busy: assert property (mem_req |-> busy && !prot_irq)
    else $error("memory request outside block");
endmodule
bind blr_exec blr_exec_asserts #(.LEVELS(LEVELS)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr_word(instr_word), .cur_ring(cur_ring), .stop_mode(stop_mode),
  .busy(busy), .done(done), .svc_irq(svc_irq), .prot_irq(prot_irq), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));

// >>> sim/blr_mem_model.sv
`timescale 1ns/1ps
// ************************************************
// main memory partner
// ************************************************
module blr_mem_model (
  input wire core_clk, // clock
  input wire rst_b, // reset
  input wire mem_req, // request
  input wire mem_we, // write
  input wire [15:0] mem_addr, // address
  input wire [15:0] mem_wdata, // data
  input wire [3:0] wait_cycles, // answer delay
  output reg mem_ack, // answer pulse
  output reg [15:0] mem_rdata // read data
);
  reg [15:0] mem [0:63];
  reg [3:0] wait_reg;
  // one answer per request; read data toggles when not answering
  always @(posedge core_clk) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_reg >= wait_cycles) begin
      mem_ack <= 1'b1;
      wait_reg <= 4'h0;
      mem_rdata <= mem[mem_addr[5:0]];
      if (mem_we)
        mem[mem_addr[5:0]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "blr_regs.vh"
// ************************************************
// execution unit bench
// ************************************************
module tb_top;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg instr_valid = 1'b0;
  reg stop_mode = 1'b0;
  reg [15:0] instr_word = 16'h0000;
  reg [15:0] cur_pc = 16'h0000;
  reg [3:0] dbg_level = 4'h0;
  reg [3:0] wait_cycles = 4'h3;
  reg [2:0] dbg_code = 3'h0;
  reg [1:0] cur_ring = 2'h1;
  reg [31:0] seed = 32'hBCAD;
  reg [15:0] rf [0:15][0:7];
  reg [3:0] exq [$];
  reg [15:0] v;
  reg [4:0] r;
  reg [3:0] e;
  integer fail_count = 0;
  integer n_tests = 0;
  integer i;
  integer k;
  wire busy, done, skip, svc_irq, prot_irq, illegal, mem_req, mem_we, mem_ack;
  wire [15:0] mem_addr, mem_wdata, mem_rdata, dbg_data;
  localparam [23:0] blk_order = {`BLR_R_B, `BLR_R_FLAG, `BLR_R_L, `BLR_R_D, `BLR_R_A, `BLR_R_T, `BLR_R_X, `BLR_R_P};
  always #4 core_clk = ~core_clk;
  blr_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
    .cur_level(4'h0), .cur_ring(cur_ring), .stop_mode(stop_mode), .cur_pc(cur_pc), .busy(busy), .done(done),
    .skip(skip), .svc_irq(svc_irq), .prot_irq(prot_irq), .illegal(illegal), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .dbg_level(dbg_level), .dbg_code(dbg_code), .dbg_data(dbg_data));
  blr_mem_model u_mem (.core_clk(core_clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // random words from the shift register
  function [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed[15:0];
  endfunction
  // bit operation model: skip, bit write, new bit, accumulator write, new accumulator
  function [4:0] single_bit_operation(input [3:0] s, input b, input kk);
    case (s)
      4'h0: single_bit_operation = {~b, 4'h0};
      4'h1: single_bit_operation = {b, 4'h0};
      4'h2: single_bit_operation = {~b == kk, 4'h0};
      4'h3: single_bit_operation = {b == kk, 4'h0};
      4'h4: single_bit_operation = 5'h08;
      4'h5: single_bit_operation = 5'h0C;
      4'h6: single_bit_operation = {2'h1, ~b, 2'h0};
      4'h7: single_bit_operation = {2'h1, kk, 2'h0};
      4'h8: single_bit_operation = {2'h1, kk, 2'h2};
      4'h9: single_bit_operation = {2'h1, ~kk, 2'h3};
      4'hA: single_bit_operation = {4'h1, b};
      4'hB: single_bit_operation = {4'h1, ~b};
      4'hC: single_bit_operation = {4'h1, ~b & kk};
      4'hD: single_bit_operation = {4'h1, ~b | kk};
      4'hE: single_bit_operation = {4'h1, b & kk};
      default: single_bit_operation = {4'h1, b | kk};
    endcase
  endfunction
  task automatic cmp(input string nm, input [15:0] ex, input [15:0] got);
    n_tests = n_tests + 1;
    if (got !== ex) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h got %h", nm, ex, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // issue one word and wait for its completion
  task exe(input [15:0] wd, input [3:0] ex);
    exq.push_back(ex);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= wd;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k = k + 1)
      @(posedge core_clk);
    if (k == 200) begin
      cmp("done", 16'h0001, 16'h0000);
      end_of_test;
    end
  endtask
  task rd(input [3:0] l, input [2:0] c);
    @(posedge core_clk);
    dbg_level <= l;
    dbg_code <= c;
    repeat (2) @(posedge core_clk);
    cmp("dbg_data", rf[l][c], dbg_data);
  endtask
  // block load model or block store check, current level 0
  task automatic blk(input [3:0] l, input st);
    integer n;
    reg [5:0] a;
    reg [2:0] c;
    reg [15:0] m;
    a = rf[0][7][5:0];
    for (n = 0; n < 8; n = n + 1) begin
      c = blk_order[n * 3 +: 3];
      m = (c == `BLR_R_FLAG) ? 16'h00FF : 16'hFFFF;
      if (st)
        cmp("mem", ((c == `BLR_R_P && l == 4'h0) ? cur_pc + 16'h0001 : rf[l][c]) & m, u_mem.mem[a]);
      else if (c != `BLR_R_P || l != 4'h0)
        rf[l][c] = u_mem.mem[a] & m;
      a = a + 6'h01;
    end
    for (n = 0; n < 8 && !st; n = n + 1)
      rd(l, n[2:0]);
  endtask
  // result watcher
  always @(posedge core_clk) begin
    if (done === 1'b1) begin
      e = exq.pop_front();
      cmp("flags", e, {skip, svc_irq, prot_irq, illegal});
    end
  end
  initial begin
    for (i = 0; i < 64; i = i + 1)
      u_mem.mem[i] = rnd();
    for (i = 0; i < 128; i = i + 1)
      rf[i / 8][i % 8] = 16'h0000;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    exe({`BLR_OP_LRB, 4'h5, `BLR_OP_LRB_LO}, 4'h2);
    exe({`BLR_OP_IRW, 4'h5, `BLR_R_B}, 4'h2);
    rd(4'h5, `BLR_R_B);
    exe(16'h0000, 4'h1);
    $display("test refusal end");
    cur_ring <= 2'h2;
    exe({`BLR_OP_LRB, 4'h0, `BLR_OP_LRB_LO}, 4'h0);
    blk(4'h0, 1'b0);
    cur_ring <= 2'h3;
    wait_cycles <= 4'h0;
    exe({`BLR_OP_LRB, 4'h5, `BLR_OP_LRB_LO}, 4'h0);
    blk(4'h5, 1'b0);
    $display("test block load end");
    cur_ring <= 2'h0;
    stop_mode <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      exe({`BLR_OP_IRR, 4'h5, i[2:0]}, 4'h0);
      rf[0][5] = rf[5][i];
      rd(4'h0, `BLR_R_A);
      exe({`BLR_OP_IRW, 4'h9, i[2:0]}, 4'h0);
      rf[9][i] = rf[0][5];
      rd(4'h9, i[2:0]);
    end
    exe({`BLR_OP_IRW, 4'h0, `BLR_R_P}, 4'h0);
    rd(4'h0, `BLR_R_P);
    $display("test cross level end");
    stop_mode <= 1'b0;
    exe({`BLR_OP_IRW, 4'h9, `BLR_R_B}, 4'h2);
    rd(4'h9, `BLR_R_B);
    for (i = 0; i < 32; i = i + 1) begin
      v = rnd();
      if (v[2:0] == 3'h0)
        v[6] = 1'b0;
      r = single_bit_operation(i[3:0], rf[0][v[2:0]][v[6:3]], rf[0][0][`BLR_K_BIT]);
      exe({`BLR_OP_BIT, i[3:0], v[6:3], v[2:0]}, {r[4], 3'h0});
      if (r[3])
        rf[0][v[2:0]][v[6:3]] = r[2];
      if (r[1])
        rf[0][0][`BLR_K_BIT] = r[0];
      rd(4'h0, v[2:0]);
      rd(4'h0, `BLR_R_FLAG);
    end
    $display("test bit operations end");
    for (i = 0; i < 3; i = i + 1) begin
      v = (i == 0) ? 16'h0080 : (i == 1) ? 16'h007F : rnd();
      exe({`BLR_OP_SVC, v[7:0]}, 4'h4);
      rf[14][6] = {{8{v[7]}}, v[7:0]};
      rd(4'hE, `BLR_R_T);
    end
    $display("test supervisor call end");
    cur_ring <= 2'h2;
    cur_pc <= rnd();
    exe({`BLR_OP_SRB, 4'h5, `BLR_OP_SRB_LO}, 4'h0);
    blk(4'h5, 1'b1);
    exe({`BLR_OP_SRB, 4'h0, `BLR_OP_SRB_LO}, 4'h0);
    blk(4'h0, 1'b1);
    $display("test block store end");
    end_of_test;
  end
endmodule
